// ==== ovp_pkg.sv ====
// Purpose: shared constants and types for the output volume and path register bank
// Assumes: 8-bit register address, 16-bit register data, four analogue output channels
// Notes:   channel index 0 hp left, 1 hp right, 2 line left, 3 line right
`default_nettype none
package ovp_pkg;

  // bus widths
  localparam int OVP_AW = 8;
  localparam int OVP_DW = 16;

  // register offsets
  localparam logic [7:0] OVP_ADDR_HP_LEFT   = 8'h39;
  localparam logic [7:0] OVP_ADDR_HP_RIGHT  = 8'h3a;
  localparam logic [7:0] OVP_ADDR_LINE_LEFT = 8'h3b;
  localparam logic [7:0] OVP_ADDR_LINE_RIGHT = 8'h3c;
  localparam logic [7:0] OVP_ADDR_SOURCE    = 8'h3d;
  localparam logic [7:0] OVP_ADDR_SERVO     = 8'h43;

  // channel indices, also the servo enable bit positions
  localparam int OVP_NUM_CH     = 4;
  localparam int OVP_CH_HP_L    = 0;
  localparam int OVP_CH_HP_R    = 1;
  localparam int OVP_CH_LINE_L  = 2;
  localparam int OVP_CH_LINE_R  = 3;

  // level register field positions
  localparam int OVP_SILENCE_BIT = 8;
  localparam int OVP_UPDATE_BIT  = 7;
  localparam int OVP_ZC_BIT      = 6;
  localparam int OVP_LEVEL_MSB   = 5;
  localparam int OVP_LEVEL_W     = 6;
  localparam int OVP_GAIN_W      = 7;

  // reset values and the code that means 0 dB
  localparam logic [5:0] OVP_HP_LEVEL_RST   = 6'h2d;
  localparam logic [5:0] OVP_LINE_LEVEL_RST = 6'h39;
  localparam logic [5:0] OVP_ZERO_DB_CODE   = 6'h39;
  localparam logic [3:0] OVP_SOURCE_RST     = 4'h0;
  localparam logic [3:0] OVP_SERVO_RST      = 4'h0;

  // what the analogue side needs for one output
  typedef struct packed {
    logic       silence;
    logic       zero_cross_en;
    logic       bypass_sel;
    logic       servo_en;
    logic [5:0] level;
    logic [6:0] gain_db;
  } ovp_chan_t;

  // whole state of the register bank
  typedef struct packed {
    logic [3:0]      silence;
    logic [3:0]      zero_cross_en;
    logic [3:0]      bypass_sel;
    logic [3:0]      servo_en;
    logic [3:0][5:0] pending;
    logic [3:0][5:0] applied;
    logic [3:0][6:0] gain_db;
    logic [15:0]     rd_data;
  } ovp_state_t;

  // code 0 is -57 dB, 1 dB per step, two's complement result
  function automatic logic [6:0] ovp_level_to_db(input logic [5:0] code);
    ovp_level_to_db = {1'b0, code} - {1'b0, OVP_ZERO_DB_CODE};
  endfunction : ovp_level_to_db

  function automatic ovp_state_t ovp_reset_state();
    ovp_state_t s;
    s = '0;
    s.bypass_sel = OVP_SOURCE_RST;
    s.servo_en   = OVP_SERVO_RST;
    for (int c = 0; c < OVP_NUM_CH; c++) begin
      s.pending[c] = (c < OVP_CH_LINE_L) ? OVP_HP_LEVEL_RST : OVP_LINE_LEVEL_RST;
      s.applied[c] = s.pending[c];
      s.gain_db[c] = ovp_level_to_db(s.pending[c]);
    end
    ovp_reset_state = s;
  endfunction : ovp_reset_state

  localparam ovp_state_t OVP_STATE_RST = ovp_reset_state();

endpackage : ovp_pkg
`default_nettype wire

// ==== ovp_output_volume_path_regs.sv ====
// Purpose: register bank for headphone and line output level, silence, zero-cross, source and servo
// Assumes: plain register port, read data valid only in the cycle after the read strobe
// Notes:   what this block does is listed below, channel order hp left, hp right, line left, line right
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ovp_output_volume_path_regs
  import ovp_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  input  wire logic [OVP_AW-1:0]       addr_i,
  input  wire logic [OVP_DW-1:0]       wr_data_i,
  input  wire logic                    wr_en_i,
  input  wire logic                    rd_en_i,
  output logic      [OVP_DW-1:0]       rd_data_o,
  output ovp_chan_t [OVP_NUM_CH-1:0]   chan_o
);

  ovp_state_t st_r;
  ovp_state_t st_nxt;

  // which channel a level register address belongs to
  logic       lvl_hit;
  logic [1:0] lvl_ch;
  logic       hp_upd;
  logic       line_upd;

  // address decode for the four level registers
  always_comb begin
    lvl_hit = 1'b1;
    lvl_ch  = 2'h0;
    case (addr_i)
      OVP_ADDR_HP_LEFT: begin
        lvl_ch = 2'(OVP_CH_HP_L);
      end
      OVP_ADDR_HP_RIGHT: begin
        lvl_ch = 2'(OVP_CH_HP_R);
      end
      OVP_ADDR_LINE_LEFT: begin
        lvl_ch = 2'(OVP_CH_LINE_L);
      end
      OVP_ADDR_LINE_RIGHT: begin
        lvl_ch = 2'(OVP_CH_LINE_R);
      end
      default: begin
        lvl_hit = 1'b0;
      end
    endcase
  end

  // next state: writes, paired level update, gain and read mux
  always_comb begin
    st_nxt   = st_r;
    hp_upd   = 1'b0;
    line_upd = 1'b0;

    // field writes, bits outside the defined fields are dropped
    if (wr_en_i && lvl_hit) begin
      st_nxt.silence[lvl_ch]       = wr_data_i[OVP_SILENCE_BIT];
      st_nxt.zero_cross_en[lvl_ch] = wr_data_i[OVP_ZC_BIT];
      st_nxt.pending[lvl_ch]       = wr_data_i[OVP_LEVEL_MSB:0];
      if (lvl_ch == 2'(OVP_CH_HP_L) || lvl_ch == 2'(OVP_CH_HP_R)) begin
        hp_upd = wr_data_i[OVP_UPDATE_BIT];
      end else begin
        line_upd = wr_data_i[OVP_UPDATE_BIT];
      end
    end
    if (wr_en_i && addr_i == OVP_ADDR_SOURCE) begin
      // register bit order is reversed against channel order
      st_nxt.bypass_sel[OVP_CH_HP_L]   = wr_data_i[3];
      st_nxt.bypass_sel[OVP_CH_HP_R]   = wr_data_i[2];
      st_nxt.bypass_sel[OVP_CH_LINE_L] = wr_data_i[1];
      st_nxt.bypass_sel[OVP_CH_LINE_R] = wr_data_i[0];
    end
    if (wr_en_i && addr_i == OVP_ADDR_SERVO) begin
      st_nxt.servo_en = wr_data_i[OVP_NUM_CH-1:0];
    end

    // the pair moves together so left and right never differ mid-change;
    // the level written in the same access is already included
    if (hp_upd) begin
      st_nxt.applied[OVP_CH_HP_L] = st_nxt.pending[OVP_CH_HP_L];
      st_nxt.applied[OVP_CH_HP_R] = st_nxt.pending[OVP_CH_HP_R];
    end
    if (line_upd) begin
      st_nxt.applied[OVP_CH_LINE_L] = st_nxt.pending[OVP_CH_LINE_L];
      st_nxt.applied[OVP_CH_LINE_R] = st_nxt.pending[OVP_CH_LINE_R];
    end

    // gain in dB follows the applied code in the same cycle
    for (int c = 0; c < OVP_NUM_CH; c++) begin
      st_nxt.gain_db[c] = ovp_level_to_db(st_nxt.applied[c]);
    end

    // read data stands for one cycle only, zero otherwise
    st_nxt.rd_data = '0;
    if (rd_en_i) begin
      if (lvl_hit) begin
        // update bit is an action, it reads back as zero
        st_nxt.rd_data[OVP_SILENCE_BIT]   = st_r.silence[lvl_ch];
        st_nxt.rd_data[OVP_ZC_BIT]        = st_r.zero_cross_en[lvl_ch];
        st_nxt.rd_data[OVP_LEVEL_MSB:0]   = st_r.pending[lvl_ch];
      end else if (addr_i == OVP_ADDR_SOURCE) begin
        st_nxt.rd_data[3] = st_r.bypass_sel[OVP_CH_HP_L];
        st_nxt.rd_data[2] = st_r.bypass_sel[OVP_CH_HP_R];
        st_nxt.rd_data[1] = st_r.bypass_sel[OVP_CH_LINE_L];
        st_nxt.rd_data[0] = st_r.bypass_sel[OVP_CH_LINE_R];
      end else if (addr_i == OVP_ADDR_SERVO) begin
        st_nxt.rd_data[OVP_NUM_CH-1:0] = st_r.servo_en;
      end
    end
  end

  // single state register, constant reset value
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= OVP_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs taken straight from the state flops
  assign rd_data_o = st_r.rd_data;
  for (genvar g = 0; g < OVP_NUM_CH; g++) begin : g_chan
    assign chan_o[g].silence       = st_r.silence[g];
    assign chan_o[g].zero_cross_en = st_r.zero_cross_en[g];
    assign chan_o[g].bypass_sel    = st_r.bypass_sel[g];
    assign chan_o[g].servo_en      = st_r.servo_en[g];
    assign chan_o[g].level         = st_r.applied[g];
    assign chan_o[g].gain_db       = st_r.gain_db[g];
  end

endmodule : ovp_output_volume_path_regs
`default_nettype wire

// ==== ovp_assertions.sv ====
// Purpose: port checks for the output level and path register bank
// Assumes: one clock, checks idle while reset is low
// Notes:   watches only the top module's ports
`timescale 1ns/100ps
`default_nettype none
module ovp_checker
  import ovp_pkg::*;
(
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_n_i,
  input  wire logic [OVP_AW-1:0]           addr_i,
  input  wire logic [OVP_DW-1:0]           wr_data_i,
  input  wire logic                        wr_en_i,
  input  wire logic                        rd_en_i,
  input  wire logic [OVP_DW-1:0]           rd_data_o,
  input  wire ovp_chan_t [OVP_NUM_CH-1:0]  chan_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // read port, gain form and write effects one cycle after the strobe
  chk_rd_idle: assert property (!$past(rd_en_i) |-> rd_data_o == 16'h0000)
    else $error("read data not idle");
  chk_gain_map: assert property (chan_o[1].gain_db == {1'b0, chan_o[1].level} - 7'h39)
    else $error("gain does not follow level");
  chk_hp_silence: assert property (wr_en_i && addr_i == 8'h3a |=> chan_o[1].silence == $past(wr_data_i[8]))
    else $error("hp right silence wrong");
  chk_hp_update: assert property (wr_en_i && addr_i == 8'h3a && wr_data_i[7]
    |=> chan_o[1].level == $past(wr_data_i[5:0]))
    else $error("hp level not applied");
  chk_line_update: assert property (wr_en_i && addr_i == 8'h3c && wr_data_i[7]
    |=> chan_o[3].level == $past(wr_data_i[5:0]))
    else $error("line level not applied");
  chk_pending_hold: assert property (wr_en_i && addr_i == 8'h3b && !wr_data_i[7]
    |=> $stable(chan_o[2].level) && $stable(chan_o[3].level))
    else $error("level applied without update");
  chk_source_sel: assert property (wr_en_i && addr_i == 8'h3d
    |=> chan_o[0].bypass_sel == $past(wr_data_i[3]))
    else $error("hp left source wrong");
  chk_servo_en: assert property (wr_en_i && addr_i == 8'h43 |=> chan_o[3].servo_en == $past(wr_data_i[3]))
    else $error("line right servo enable wrong");
endmodule : ovp_checker
bind ovp_output_volume_path_regs ovp_checker chk_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .chan_o(chan_o));
`default_nettype wire

// ==== test_ovp_output_volume_path_regs.sv ====
// Purpose: self-checking bench for the output level and path register bank
// Assumes: register model below steps on the same edges as the design
// Notes:   seeded random traffic, two resets, unmapped address in the table
`timescale 1ns/100ps
`default_nettype none
module test_ovp_output_volume_path_regs import ovp_pkg::*;;
  logic            clk_sys_i = 0;
  logic            rst_n_i = 0;
  logic [7:0]      addr_i = 0;
  logic [15:0]     wr_data_i = 0;
  logic            wr_en_i = 0;
  logic            rd_en_i = 0;
  logic [15:0]     rd_data_o;
  ovp_chan_t [3:0] chan_o;
  logic [15:0]     rg [57:67];
  logic [5:0]      app [4];
  logic [15:0]     exp_rd;
  logic [7:0]      tbl [7] = '{8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h43, 8'h40};
  int              failures, samples_checked, k, b;
  bit              run;

  ovp_output_volume_path_regs dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .chan_o(chan_o));
  // 40 MHz clock
  always #12.5 clk_sys_i = ~clk_sys_i;

  task automatic cmp(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : cmp

  // model samples the same inputs as the design, compares after outputs settle
  always @(posedge clk_sys_i) begin
    if (run) begin
      exp_rd = (rd_en_i && addr_i inside {[8'h39:8'h3d], 8'h43}) ? rg[addr_i] : 16'h0000;
      if (wr_en_i && addr_i inside {[8'h39:8'h3d], 8'h43}) begin
        rg[addr_i] = wr_data_i & (addr_i < 8'h3d ? 16'h017f : 16'h000f);
        b = (addr_i - 8'h39) & 2;
        if (addr_i < 8'h3d && wr_data_i[7]) app[b] = rg[57 + b][5:0];
        if (addr_i < 8'h3d && wr_data_i[7]) app[b + 1] = rg[58 + b][5:0];
      end
      #1;
      cmp("rd_data", {1'b0, rd_data_o}, {1'b0, exp_rd});
      for (int c = 0; c < 4; c++) begin
        cmp("silence", chan_o[c].silence, rg[57 + c][8]);
        cmp("zero_cross", chan_o[c].zero_cross_en, rg[57 + c][6]);
        cmp("bypass", chan_o[c].bypass_sel, rg[61][3 - c]);
        cmp("servo", chan_o[c].servo_en, rg[67][c]);
        cmp("level_gain", chan_o[c][12:0], {app[c], {1'b0, app[c]} - 7'h39});
      end
    end
  end

  // reset values first, then random back-to-back traffic; a second reset mid-run
  initial begin
    void'($urandom(52899));
    repeat (2) begin
      run = 0;
      @(posedge clk_sys_i);
      rst_n_i <= 0;
      // model cleared at the same edge that drives reset low, with run already off so nothing is compared
      rg = '{57: 16'h002d, 58: 16'h002d, 59: 16'h0039, 60: 16'h0039, default: 16'h0000};
      app = '{6'h2d, 6'h2d, 6'h39, 6'h39};
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1;
      run = 1;
      for (int i = 0; i < 407; i++) begin
        k = (i < 7) ? 2 : $urandom % 3;
        @(posedge clk_sys_i);
        {wr_en_i, rd_en_i, addr_i, wr_data_i} <= {k == 1, k == 2, tbl[i < 7 ? i : $urandom % 7], 16'($urandom)};
      end
      @(posedge clk_sys_i);
      {wr_en_i, rd_en_i} <= 2'b00;
      repeat (2) @(posedge clk_sys_i);
    end
    end_sim();
  end

  // traffic needs under 900 cycles; cut a hang at 5000
  initial begin
    #125000;
    failures++;
    end_sim();
  end

  task automatic end_sim;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
endmodule : test_ovp_output_volume_path_regs
`default_nettype wire
